// ==== logic/gpe_defs.svh ====
// Purpose: offsets, reset values and codes for the gpio edge port
// Assumes: register indices times four give byte addresses
// Notes: definitions only
`ifndef GPE_DEFS_SVH
`define GPE_DEFS_SVH

`define GPE_NPINS      8
`define GPE_AW         12
// register indices, byte address is index * 4
`define GPE_IDX_DIR    10'h05a
`define GPE_IDX_LEVEL  10'h05c
`define GPE_IDX_RISE   10'h05e
`define GPE_IDX_FALL   10'h060
`define GPE_IDX_STAT   10'h062
`define GPE_IDX_CLR    10'h066
`define GPE_IDX_IEN    10'h068
// reset values
`define GPE_RST_ZERO   8'h00
`define GPE_RST_IEN    8'hff
// axi responses
`define GPE_RESP_OKAY  2'h0
`define GPE_RESP_SLV   2'h2

`endif

// ==== logic/gpe_pkg.sv ====
// Purpose: shared types of the gpio edge port
// Assumes: gpe_defs.svh holds the numbers
// Notes: write channel walks idle, addr or data, resp
`default_nettype none
package gpe_pkg;
	typedef logic [7:0] gpe_pins_t;
	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_ADDR = 2'h1,
		WR_RESP = 2'h3,
		WR_DATA = 2'h2
	} gpe_wr_state_t;
endpackage
`default_nettype wire

// ==== logic/gpe_port_edge_irq.sv ====
// Purpose: eight pin gpio port with edge interrupts, axi4-lite slave
// Assumes: pins asynchronous inputs, one write and one read in flight
// Notes: irq is a level, high while an enabled status bit is set
//
// Functional notes
// R1: each direction bit, 0 input, 1 output driven by the port
// R2: output pin follows its written level bit
// R3: input pin level bit reads the present pin level
// R4: edge detection works for input and output pins alike
// R5: writing an output pin level can raise an edge interrupt
// R6: rise enable 1 lets a 0 to 1 change interrupt, else ignored
// R7: fall enable 1 lets a 1 to 0 change interrupt, else ignored
// R8: enabled edge sets irq high and that pin's status bit
// R9: irq drops only when software clears the causing status bit; writing 0 to its ien bit also drops it here
// R10: all port registers read zero after reset; here ien resets to and reads ff
// R11: one status bit per pin marks which pin interrupted
// R12: software clears a status bit by writing 1 then 0
// R13: an edge during the clear sets the bit again at once
// R14: irq ors the status bits, both enables trigger both edges
// R15: input pins synchronised first so each edge counts once
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "gpe_defs.svh"
`default_nettype none

module gpe_port_edge_irq (
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	input  wire logic [`GPE_AW-1:0]   s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [`GPE_AW-1:0]   s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire gpe_pkg::gpe_pins_t   portPinIn,
	output gpe_pkg::gpe_pins_t        portPinOut,
	output gpe_pkg::gpe_pins_t        portPinOe,
	output logic                      irqOut
);
	import gpe_pkg::*;

	gpe_wr_state_t     wrState_q;
	logic [`GPE_AW-1:0] awAddr_q;
	logic [31:0]       wData_q;
	logic [3:0]        wStrb_q;
	logic              doWrite;
	logic [`GPE_AW-1:0] wrAddr;
	logic [31:0]       wrData;
	logic [3:0]        wrStrb;
	logic              wrHit;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              arTaken;
	gpe_pins_t         dir_q;
	gpe_pins_t         level_q;
	gpe_pins_t         rise_q;
	gpe_pins_t         fall_q;
	gpe_pins_t         status_q;
	gpe_pins_t         armed_q;
	gpe_pins_t         ien_q;
	gpe_pins_t         syncA_q;
	gpe_pins_t         pinSync_q;
	gpe_pins_t         prev_q;
	gpe_pins_t         effLevel;
	gpe_pins_t         riseEvt;
	gpe_pins_t         fallEvt;
	gpe_pins_t         edgeEvt;
	gpe_pins_t         clrMask;
	gpe_pins_t         levelRead;
	logic              wrDir;
	logic              wrLevel;
	logic              wrRise;
	logic              wrFall;
	logic              wrStat;
	logic              wrClr;
	logic              wrIen;

	////////////////////////////////////////////////////////////////
	// write channels, address and data taken in either order
	assign s_axi_awready = (wrState_q == WR_IDLE) ||
		(wrState_q == WR_DATA);
	assign s_axi_wready  = (wrState_q == WR_IDLE) ||
		(wrState_q == WR_ADDR);
	assign doWrite = ((wrState_q == WR_IDLE) && s_axi_awvalid &&
		s_axi_wvalid) ||
		((wrState_q == WR_ADDR) && s_axi_wvalid) ||
		((wrState_q == WR_DATA) && s_axi_awvalid);
	assign wrAddr = (wrState_q == WR_ADDR) ? awAddr_q : s_axi_awaddr;
	assign wrData = (wrState_q == WR_DATA) ? wData_q : s_axi_wdata;
	assign wrStrb = (wrState_q == WR_DATA) ? wStrb_q : s_axi_wstrb;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wrState_q <= WR_IDLE;
		end else begin
			case (wrState_q)
				WR_IDLE: begin
					if (doWrite) begin
						wrState_q <= WR_RESP;
					end else if (s_axi_awvalid) begin
						wrState_q <= WR_ADDR;
					end else if (s_axi_wvalid) begin
						wrState_q <= WR_DATA;
					end
				end
				WR_ADDR, WR_DATA: begin
					if (doWrite) begin
						wrState_q <= WR_RESP;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						wrState_q <= WR_IDLE;
					end
				end
				default: wrState_q <= WR_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			awAddr_q <= '0;
			wData_q  <= '0;
			wStrb_q  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
		end
	end

	// decode of the selected register, strobe of the low lane only
	always_comb begin
		wrDir   = 1'b0;
		wrLevel = 1'b0;
		wrRise  = 1'b0;
		wrFall  = 1'b0;
		wrStat  = 1'b0;
		wrClr   = 1'b0;
		wrIen   = 1'b0;
		wrHit   = 1'b1;
		if (wrAddr == {`GPE_IDX_DIR, 2'b00}) begin
			wrDir = doWrite && wrStrb[0];
		end else if (wrAddr == {`GPE_IDX_LEVEL, 2'b00}) begin
			wrLevel = doWrite && wrStrb[0];
		end else if (wrAddr == {`GPE_IDX_RISE, 2'b00}) begin
			wrRise = doWrite && wrStrb[0];
		end else if (wrAddr == {`GPE_IDX_FALL, 2'b00}) begin
			wrFall = doWrite && wrStrb[0];
		end else if (wrAddr == {`GPE_IDX_STAT, 2'b00}) begin
			wrStat = doWrite && wrStrb[0];
		end else if (wrAddr == {`GPE_IDX_CLR, 2'b00}) begin
			wrClr = doWrite && wrStrb[0];
		end else if (wrAddr == {`GPE_IDX_IEN, 2'b00}) begin
			wrIen = doWrite && wrStrb[0];
		end else begin
			wrHit = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `GPE_RESP_OKAY;
		end else if (doWrite) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wrHit ? `GPE_RESP_OKAY : `GPE_RESP_SLV;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	////////////////////////////////////////////////////////////////
	// port registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dir_q   <= `GPE_RST_ZERO; // [R10]
			level_q <= `GPE_RST_ZERO; // [R10]
			rise_q  <= `GPE_RST_ZERO; // [R10]
			fall_q  <= `GPE_RST_ZERO; // [R10]
			ien_q   <= `GPE_RST_IEN;
		end else begin
			if (wrDir) begin
				dir_q <= wrData[7:0]; // [R1]
			end
			if (wrLevel) begin
				level_q <= wrData[7:0]; // [R2]
			end
			if (wrRise) begin
				rise_q <= wrData[7:0];
			end
			if (wrFall) begin
				fall_q <= wrData[7:0];
			end
			if (wrIen) begin
				ien_q <= wrData[7:0];
			end
		end
	end
	// pad drive straight from flops, no glitch on the pins
	assign portPinOut = level_q; // [R2]
	assign portPinOe  = dir_q; // [R1]

	////////////////////////////////////////////////////////////////
	// synchroniser and edge detection
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			syncA_q   <= '0;
			pinSync_q <= '0;
			prev_q    <= '0;
		end else begin
			syncA_q   <= portPinIn; // [R15]
			pinSync_q <= syncA_q; // [R15]
			prev_q    <= effLevel;
		end
	end

	// output pins use the written level so a write makes the edge
	assign effLevel = (dir_q & level_q) | (~dir_q & pinSync_q); // [R4] [R5]
	assign riseEvt  = effLevel & ~prev_q & rise_q; // [R6]
	assign fallEvt  = ~effLevel & prev_q & fall_q; // [R7]
	assign edgeEvt  = riseEvt | fallEvt; // [R14]

	////////////////////////////////////////////////////////////////
	// status bits, set wins over clear
	genvar gi;
	generate
		for (gi = 0; gi < `GPE_NPINS; gi = gi + 1) begin : g_pin
			assign clrMask[gi] = (wrStat && armed_q[gi] &&
				!wrData[gi]) || (wrClr && wrData[gi]); // [R12]
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					status_q[gi] <= 1'b0; // [R10]
					armed_q[gi]  <= 1'b0;
				end else begin
					// [R8] [R11] [R13]
					status_q[gi] <= edgeEvt[gi] |
						(status_q[gi] & ~clrMask[gi]);
					if (wrStat) begin
						armed_q[gi] <= wrData[gi]; // [R12]
					end
				end
			end
		end
	endgenerate

	assign irqOut = |(status_q & ien_q); // [R8] [R9] [R14]

	////////////////////////////////////////////////////////////////
	// read channel, one cycle to rvalid
	assign arTaken       = s_axi_arvalid && !rvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign levelRead     = (dir_q & level_q) | (~dir_q & pinSync_q); // [R3]

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= `GPE_RESP_OKAY;
		end else if (arTaken) begin
			rvalid_q <= 1'b1;
			rresp_q  <= `GPE_RESP_OKAY;
			rdata_q  <= '0;
			if (s_axi_araddr == {`GPE_IDX_DIR, 2'b00}) begin
				rdata_q[7:0] <= dir_q;
			end else if (s_axi_araddr == {`GPE_IDX_LEVEL, 2'b00}) begin
				rdata_q[7:0] <= levelRead; // [R3]
			end else if (s_axi_araddr == {`GPE_IDX_RISE, 2'b00}) begin
				rdata_q[7:0] <= rise_q;
			end else if (s_axi_araddr == {`GPE_IDX_FALL, 2'b00}) begin
				rdata_q[7:0] <= fall_q;
			end else if (s_axi_araddr == {`GPE_IDX_STAT, 2'b00}) begin
				rdata_q[7:0] <= status_q; // [R11]
			end else if (s_axi_araddr == {`GPE_IDX_CLR, 2'b00}) begin
				rdata_q[7:0] <= `GPE_RST_ZERO;
			end else if (s_axi_araddr == {`GPE_IDX_IEN, 2'b00}) begin
				rdata_q[7:0] <= ien_q;
			end else begin
				rresp_q <= `GPE_RESP_SLV;
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	chk_dir_drives_oe: assert property ( // [R1]
		wrDir |=> portPinOe == $past(wrData[7:0]))
		else $error("direction write not on output enables");

	chk_level_drives_pin: assert property ( // [R2]
		wrLevel |=> portPinOut == $past(wrData[7:0]))
		else $error("level write not on pin outputs");

	chk_input_readback: assert property ( // [R3]
		arTaken && (s_axi_araddr == {`GPE_IDX_LEVEL, 2'b00}) |=>
		((s_axi_rdata[7:0] ^ $past(pinSync_q)) & ~$past(dir_q))
		== `GPE_RST_ZERO)
		else $error("input pin read differs from pin");

	chk_output_edge: assert property ( // [R5]
		wrLevel && |(dir_q & rise_q & ~level_q & wrData[7:0])
		|-> ##[1:2] (|status_q))
		else $error("output rising write raised no status");

	chk_rise_sets: assert property ( // [R6]
		(|riseEvt) |=> (status_q & $past(riseEvt)) == $past(riseEvt))
		else $error("enabled rise did not set status");

	chk_fall_sets: assert property ( // [R7]
		(|fallEvt) |=> (status_q & $past(fallEvt)) == $past(fallEvt))
		else $error("enabled fall did not set status");

	chk_no_spurious: assert property ( // [R11]
		1'b1 |=> (status_q & $past(~status_q & ~edgeEvt))
		== `GPE_RST_ZERO)
		else $error("status set without an enabled edge");

	chk_irq_raise: assert property ( // [R8]
		(|(edgeEvt & ien_q)) && !wrIen |=> irqOut)
		else $error("irq not raised after enabled edge");

	chk_irq_holds: assert property ( // [R9]
		irqOut && !(|clrMask) && !wrIen |=> irqOut)
		else $error("irq fell without a clear");

	chk_set_wins: assert property ( // [R13]
		(|(edgeEvt & clrMask)) |=>
		(status_q & $past(edgeEvt)) == $past(edgeEvt))
		else $error("clear beat a same cycle edge");

	chk_edge_once: assert property ( // [R15]
		1'b1 |-> (edgeEvt & ~dir_q & ~$past(dir_q) &
		~(pinSync_q ^ $past(pinSync_q))) == `GPE_RST_ZERO)
		else $error("input edge without a synced pin change");

	chk_reset_zero: assert property ( // [R10]
		@(posedge ref_clk) disable iff (1'b0)
		!nrst |=> (dir_q | level_q | rise_q | fall_q | status_q)
		== `GPE_RST_ZERO)
		else $error("registers not zero after reset");

	cov_input_rise: cover property (
		|(riseEvt & ~dir_q) ##1 irqOut);
	cov_input_fall: cover property (
		|(fallEvt & ~dir_q) ##1 irqOut);
	cov_output_edge: cover property (
		|(edgeEvt & dir_q));
	cov_two_step_clear: cover property (
		irqOut && (|clrMask) ##1 !irqOut);

endmodule
`default_nettype wire

// ==== bench/gpe_pin_model.sv ====
// Purpose: external devices sitting on the eight port pins
// Assumes: the port drives a pin only while its enable is high
// Notes: pull-downs left out, a released pin shows the device level
`timescale 1ns/1ns
`default_nettype none
module gpe_pin_model (
	input  wire gpe_pkg::gpe_pins_t extLevel,
	input  wire gpe_pkg::gpe_pins_t portPinOut,
	input  wire gpe_pkg::gpe_pins_t portPinOe,
	output gpe_pkg::gpe_pins_t      portPinIn
);
	import gpe_pkg::*;
	// port wins where enabled, else the device drives
	assign portPinIn = (portPinOe & portPinOut) | (~portPinOe & extLevel);
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for the gpio edge port
// Assumes: axi4-lite answers after one cycle, pins synced in two
// Notes: reads note {irq, resp, data}, a monitor compares them
`timescale 1ns/1ns
`include "gpe_defs.svh"
`default_nettype none
module testbench;
	import gpe_pkg::*;
	localparam logic [11:0] A_DIR  = {`GPE_IDX_DIR, 2'h0};
	localparam logic [11:0] A_LVL  = {`GPE_IDX_LEVEL, 2'h0};
	localparam logic [11:0] A_RISE = {`GPE_IDX_RISE, 2'h0};
	localparam logic [11:0] A_FALL = {`GPE_IDX_FALL, 2'h0};
	localparam logic [11:0] A_STAT = {`GPE_IDX_STAT, 2'h0};
	localparam logic [11:0] A_CLR  = {`GPE_IDX_CLR, 2'h0};
	localparam logic [11:0] A_IEN  = {`GPE_IDX_IEN, 2'h0};
	localparam logic [11:0] A_BAD  = 12'h004;
	localparam logic [1:0]  OK     = `GPE_RESP_OKAY;
	logic        ref_clk, nrst, irqOut;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	gpe_pins_t   extLevel, pinIn, pinOut, pinOe, d, l, e;
	logic [34:0] rdQ[$];
	logic [1:0]  wrQ[$];
	int          error_cnt, n_checks, seed;
	logic [11:0] regs [5] = '{A_DIR, A_LVL, A_RISE, A_FALL, A_STAT};
	gpe_port_edge_irq dut (.ref_clk(ref_clk), .nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .portPinIn(pinIn),
		.portPinOut(pinOut), .portPinOe(pinOe), .irqOut(irqOut));
	gpe_pin_model pins (.extLevel(extLevel), .portPinOut(pinOut),
		.portPinOe(pinOe), .portPinIn(pinIn));
	////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [34:0] seen,
			input logic [34:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic axiWrite(input logic [11:0] a, input gpe_pins_t v,
			input logic [1:0] r);
		logic aw, w;
		@(posedge ref_clk);
		wrQ.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_wstrb <= 4'h1 | 4'($random(seed));
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		while (!(aw && w)) begin
			@(posedge ref_clk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge ref_clk);
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axiRead(input logic [11:0] a, input logic irq,
			input logic [1:0] r, input gpe_pins_t v);
		@(posedge ref_clk);
		rdQ.push_back({irq, r, 24'h00_0000, v});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge ref_clk);
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	// results compared at the handshake edge, oldest note first
	always @(posedge ref_clk) begin
		if (s_axi_rvalid && s_axi_rready)
			check("read", {irqOut, s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			check("bresp", 35'(s_axi_bresp), 35'(wrQ.pop_front()));
	end
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 39522;
		{nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, extLevel} = 64'h0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		check("pins", 35'({irqOut, pinOe, pinOut}), 35'h0);
		foreach (regs[i]) axiRead(regs[i], 1'b0, OK, 8'h00);
		// random direction, level and device values
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			l = 8'($random(seed));
			e = 8'($random(seed));
			extLevel <= e;
			axiWrite(A_DIR, d, OK);
			axiWrite(A_LVL, l, OK);
			check("oe", 35'(pinOe), 35'(d));
			check("out", 35'(pinOut & d), 35'(l & d));
			axiRead(A_LVL, 1'b0, OK, (l & d) | (e & ~d));
		end
		axiWrite(A_DIR, 8'h00, OK);
		extLevel <= 8'h00;
		repeat (4) @(posedge ref_clk);
		axiWrite(A_RISE, 8'h01, OK);
		axiWrite(A_FALL, 8'h02, OK);
		extLevel <= 8'h07;
		repeat (4) @(posedge ref_clk);
		axiRead(A_STAT, 1'b1, OK, 8'h01);
		extLevel <= 8'h00;
		repeat (4) @(posedge ref_clk);
		axiRead(A_STAT, 1'b1, OK, 8'h03);
		// mask bit 1, clear bit 0 through the clear word
		axiWrite(A_IEN, 8'h01, OK);
		axiWrite(A_CLR, 8'h01, OK);
		axiRead(A_STAT, 1'b0, OK, 8'h02);
		axiRead(A_IEN, 1'b0, OK, 8'h01);
		axiWrite(A_IEN, 8'hff, OK);
		axiWrite(A_STAT, 8'h02, OK);
		axiRead(A_STAT, 1'b1, OK, 8'h02);
		axiWrite(A_STAT, 8'h00, OK);
		axiRead(A_STAT, 1'b0, OK, 8'h00);
		// output pin edges made by level writes
		axiWrite(A_LVL, 8'h00, OK);
		axiWrite(A_RISE, 8'h10, OK);
		axiWrite(A_FALL, 8'h10, OK);
		axiWrite(A_DIR, 8'h10, OK);
		axiWrite(A_LVL, 8'h10, OK);
		repeat (2) @(posedge ref_clk);
		axiRead(A_STAT, 1'b1, OK, 8'h10);
		axiWrite(A_STAT, 8'h10, OK);
		axiWrite(A_STAT, 8'h00, OK);
		axiWrite(A_LVL, 8'h00, OK);
		repeat (2) @(posedge ref_clk);
		axiRead(A_STAT, 1'b1, OK, 8'h10);
		axiWrite(A_BAD, 8'hff, `GPE_RESP_SLV);
		axiRead(A_BAD, 1'b1, `GPE_RESP_SLV, 8'h00);
		axiRead(A_CLR, 1'b1, OK, 8'h00);
		// pin falls in the very cycle its clear commits
		axiWrite(A_RISE, 8'h14, OK);
		axiWrite(A_FALL, 8'h14, OK);
		extLevel <= 8'h04;
		repeat (4) @(posedge ref_clk);
		extLevel <= 8'h00;
		@(posedge ref_clk);
		axiWrite(A_CLR, 8'h04, OK);
		axiRead(A_STAT, 1'b1, OK, 8'h14);
		axiWrite(A_CLR, 8'h14, OK);
		axiRead(A_STAT, 1'b0, OK, 8'h00);
		repeat (2) @(posedge ref_clk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
